// ---- bench/frp_mem_master.sv ----
// Access requester standing in for debug probe and bus masters
module frp_mem_master
  import frp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire frp_acc_s req_acc,
  output frp_acc_s mem_acc
);
  timeunit 1ns;
  timeprecision 1ns;
  frp_acc_s acc_q;
  frp_acc_s acc_d;
  always_comb begin
    // Idle fields toggle so a stale request never looks steady
    acc_d = ~acc_q;
    acc_d.valid = 1'b0;
    if (req) begin
      acc_d = req_acc;
      acc_d.valid = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      acc_q <= '0;
    else
      acc_q <= acc_d;
  end
  assign mem_acc = acc_q;
endmodule

// ---- bench/frp_top_bench.sv ----
// Self-checking bench of the protection block
module frp_top_bench
  import frp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIPE = 8;
  logic pclk, presetn, psel, penable, pwrite, opt_load, opt_sec_ext;
  logic opt_key_set, req, pready, pslverr, mem_grant, mem_error, err;
  logic debug_enable, ram_boot_enable, flash_wipe, backup_clear, sram_wipe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, opt_password, rd, pw;
  logic [31:0] seed = 32'h0000_de5e;
  logic [1:0] opt_level;
  frp_acc_s req_acc, mem_acc, a;
  int fails, check_count, n;
  logic [2:0] lv [4] = '{3'h0, 3'h5, 3'h2, 3'h3};
  int pg [6] = '{10, 20, 9, 21, 15, 127};
  frp_op_e ops [6] = '{FRP_OP_WRITE, FRP_OP_ERASE, FRP_OP_WRITE,
    FRP_OP_WRITE, FRP_OP_READ, FRP_OP_ERASE};
  logic [5:0] dn = 6'h23;

  frp_top #(.WIPE_CYCLES(WIPE)) frp_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .opt_load, .opt_level,
    .opt_sec_ext, .opt_key_set, .opt_password, .mem_acc, .mem_grant,
    .mem_error, .debug_enable, .ram_boot_enable, .flash_wipe,
    .backup_clear, .sram_wipe
  );
  frp_mem_master frp_mem_master_inst (
    .pclk, .presetn, .req, .req_acc, .mem_acc
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic deny_of(input logic [1:0] l, input frp_acc_s x);
    logic ext;
    ext = x.debug | x.ram_boot;
    if (l == FRP_LVL_2 && ext)
      return 1'b1;
    if (x.area == FRP_AREA_SYSMEM)
      return x.op != FRP_OP_READ;
    if (l == FRP_LVL_1 && ext && x.area != FRP_AREA_OTP)
      return 1'b1;
    return l == FRP_LVL_0P5 && x.debug && x.secure &&
      x.area != FRP_AREA_OTP;
  endfunction

  task automatic end_of_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic acc(input frp_acc_s x, input logic d);
    @(posedge pclk);
    req <= 1'b1;
    req_acc <= x;
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    #1;
    chkf({mem_grant, mem_error}, {~d, d});
  endtask

  // Options are synchronised inside, so the level settles some edges later
  task automatic ld(input logic [1:0] l, input logic s, input logic k);
    @(posedge pclk);
    opt_level <= l;
    opt_sec_ext <= s;
    opt_key_set <= k;
    @(posedge pclk);
    opt_load <= 1'b1;
    repeat (2) @(posedge pclk);
    opt_load <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic wt(input logic v);
    n = 0;
    while (sram_wipe !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (sram_wipe !== v) begin
      fails++;
      end_of_test();
    end
  endtask

  initial begin
    {presetn, psel, penable, pwrite, opt_load, opt_sec_ext} = '0;
    {opt_key_set, req, paddr, pwdata, opt_level, opt_password} = '0;
    req_acc = '0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ld(FRP_LVL_0, 1'b0, 1'b0);
    apb(1'b1, FRP_OFS_WPA0, 32'h0001_140a);
    apb(1'b1, FRP_OFS_WPA1, 32'h0001_7f7f);
    apb(1'b0, FRP_OFS_WPA0, 32'h0);
    chk(rd, 32'h0001_140a);
    for (int i = 0; i < 6; i++) begin
      a = '0;
      a.op = ops[i];
      a.page = pg[i][6:0];
      acc(a, dn[i]);
    end
    apb(1'b1, FRP_OFS_ACC, 32'h0011_0140);
    apb(1'b0, FRP_OFS_ACC, 32'h0);
    chk(rd, 32'h0011_0140);
    apb(1'b0, FRP_OFS_VERDCT, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, FRP_OFS_WPA0, 32'h0);
    apb(1'b1, FRP_OFS_WPA1, 32'h0);
    a.area = FRP_AREA_OTP;
    a.otp_row = 5'h3;
    a.op = FRP_OP_WRITE;
    acc(a, 1'b0);
    acc(a, 1'b1);
    a.op = FRP_OP_READ;
    acc(a, 1'b0);
    apb(1'b0, FRP_OFS_OTPST, 32'h0);
    chk(rd, 32'h0000_0008);
    apb(1'b0, 12'h024, 32'h0);
    chkf({1'b0, err}, 2'b01);
    for (int i = 0; i < 4; i++) begin
      ld(lv[i][1:0], lv[i][2], 1'b0);
      apb(1'b0, FRP_OFS_LEVEL, 32'h0);
      chk(rd, {29'h0, lv[i]});
      chkf({debug_enable, ram_boot_enable}, {2{i != 3}});
      repeat (25) begin
        rd = xs();
        a = rd[20:0];
        a.secure = a.secure & a.debug;
        if (a.area != FRP_AREA_MAIN || a.op > FRP_OP_ERASE)
          a.op = a.op[0] ? FRP_OP_WRITE : FRP_OP_READ;
        if (a.area == FRP_AREA_OTP)
          a.op = FRP_OP_READ;
        acc(a, deny_of(lv[i][1:0], a));
      end
    end
    ld(FRP_LVL_0P5, 1'b0, 1'b0);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h2);
    ld(FRP_LVL_1, 1'b1, 1'b0);
    chkf({debug_enable, ram_boot_enable}, 2'b10);
    a = '0;
    a.ram_boot = 1'b1;
    acc(a, 1'b1);
    a.ram_boot = 1'b0;
    ld(FRP_LVL_1, 1'b0, 1'b0);
    apb(1'b1, FRP_OFS_REQ, 32'h0);
    wt(1'b1);
    chkf({flash_wipe, backup_clear}, 2'b11);
    acc(a, 1'b1);
    wt(1'b0);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, FRP_OFS_REQ, 32'h1);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h2);
    pw = xs();
    opt_password <= pw;
    ld(FRP_LVL_2, 1'b0, 1'b1);
    apb(1'b1, FRP_OFS_KEY, ~pw);
    apb(1'b1, FRP_OFS_REQ, 32'h2);
    apb(1'b0, FRP_OFS_STAT, 32'h0);
    chkf({1'b0, rd[11]}, 2'b01);
    apb(1'b1, FRP_OFS_KEY, pw);
    apb(1'b1, FRP_OFS_REQ, 32'h2);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, FRP_OFS_KEY, ~pw);
    apb(1'b1, FRP_OFS_REQ, 32'h0);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h2);
    chkf({1'b0, sram_wipe}, 2'b00);
    ld(FRP_LVL_2, 1'b0, 1'b0);
    apb(1'b1, FRP_OFS_KEY, pw);
    apb(1'b1, FRP_OFS_REQ, 32'h2);
    apb(1'b0, FRP_OFS_LEVEL, 32'h0);
    chk(rd, 32'h3);
    chkf({debug_enable, ram_boot_enable}, 2'b00);
    end_of_test();
  end
endmodule

// ---- bench/frp_top_sva.sv ----
// Checker of the access verdict and wipe outputs
module frp_top_chk
  import frp_pkg::*;
#(
  parameter int WIPE_CYCLES = FRP_WIPE_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire frp_acc_s mem_acc,
  input wire logic mem_grant,
  input wire logic mem_error,
  input wire logic debug_enable,
  input wire logic ram_boot_enable,
  input wire logic flash_wipe,
  input wire logic backup_clear,
  input wire logic sram_wipe
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  int cnt_d;
  // Wipe too long for a repetition, so its cycles are counted
  always_comb begin
    cnt_d = sram_wipe ? cnt_q + 1 : 0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= 0;
    else
      cnt_q <= cnt_d;
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence acc_req;
    mem_acc.valid;
  endsequence
  sequence one_answer;
    ##1 (mem_grant ^ mem_error);
  endsequence
  acc_answer_a: assert property (acc_req |-> one_answer)
    else $error("access not answered once");
  acc_quiet_a: assert property (
    !mem_acc.valid |=> !(mem_grant || mem_error))
    else $error("answer without access");
  dbg_block_a: assert property (
    acc_req ##0 (mem_acc.debug && !debug_enable) |=> mem_error)
    else $error("debug access passed");
  boot_block_a: assert property (
    acc_req ##0 (mem_acc.ram_boot && !ram_boot_enable) |=> mem_error)
    else $error("ram boot access passed");
  otp_read_a: assert property (
    acc_req ##0 (mem_acc.area == FRP_AREA_OTP && mem_acc.op == FRP_OP_READ
    && !mem_acc.debug && !mem_acc.ram_boot && !sram_wipe) |=> mem_grant)
    else $error("otp read refused");
  wipe_pair_a: assert property (
    flash_wipe |-> sram_wipe && backup_clear)
    else $error("flash wipe alone");
  wipe_len_a: assert property (
    sram_wipe |-> backup_clear && cnt_q < WIPE_CYCLES)
    else $error("wipe too long");
  wipe_end_a: assert property ($fell(sram_wipe) |-> cnt_q == WIPE_CYCLES)
    else $error("wipe length wrong");
  wipe_deny_a: assert property (
    acc_req ##0 sram_wipe |=> mem_error)
    else $error("access during wipe");
  l2_lock_a: assert property (!debug_enable |-> !ram_boot_enable)
    else $error("ram boot open while debug shut");
endmodule

bind frp_top frp_top_chk #(.WIPE_CYCLES(WIPE_CYCLES)) frp_top_chk_inst (
  .pclk, .presetn, .mem_acc, .mem_grant, .mem_error, .debug_enable,
  .ram_boot_enable, .flash_wipe, .backup_clear, .sram_wipe
);

// ---- rtl/frp_access_check.sv ----
// Combinational verdict for one memory access against the protection state
module frp_access_check
  import frp_pkg::*;
(
  input wire logic [1:0] level,
  input wire logic sec_ext,
  input wire frp_wpa_s wpa0,
  input wire frp_wpa_s wpa1,
  input wire frp_acc_s acc,
  input wire logic otp_used,
  output logic deny
);
  function automatic logic in_wpa(input frp_wpa_s w,
                                  input logic [FRP_PAGE_W-1:0] p);
    in_wpa = w.en && (p >= w.start) && (p <= w.last);
  endfunction

  logic ext;
  logic wr;
  always_comb begin
    ext = acc.debug || acc.ram_boot;
    wr = (acc.op != FRP_OP_READ);
    deny = 1'b0;
    case (acc.area)
      FRP_AREA_MAIN: begin
        if (wr && (in_wpa(wpa0, acc.page) || in_wpa(wpa1, acc.page)))
          deny = 1'b1; // see RQ11 see RQ12 see RQ3
        if (ext) begin
          case (level)
            FRP_LVL_0P5: deny = deny || acc.secure; // see RQ4
            FRP_LVL_1: deny = !(sec_ext && acc.debug && !acc.secure)
                              || deny; // see RQ5 see RQ6 see RQ14
            FRP_LVL_2: deny = 1'b1; // see RQ8 see RQ9
            default: deny = deny;
          endcase
        end
      end
      FRP_AREA_SYSMEM: deny = wr || (ext && level == FRP_LVL_2);
      FRP_AREA_OTP: begin
        // Readable at every level except by debug or RAM boot at level 2, or RAM boot at level 1 with extension; each row takes one program only
        deny = (wr && otp_used) || (acc.op == FRP_OP_ERASE)
               || (ext && level == FRP_LVL_2); // see RQ13 see RQ18
      end
      FRP_AREA_BKP: begin
        // Backup registers and SRAM2 share the debug verdict
        if (ext)
          deny = (level == FRP_LVL_2) || (level == FRP_LVL_1) ||
                 (level == FRP_LVL_0P5 && acc.secure); // see RQ14
        if (acc.op == FRP_OP_ERASE)
          deny = 1'b1;
      end
      default: deny = 1'b1;
    endcase
    // Boot from SRAM is shut for every area at level 1 with the extension
    if (sec_ext && level == FRP_LVL_1 && acc.ram_boot)
      deny = 1'b1; // see RQ6
    if (!acc.valid)
      deny = 1'b0;
  end
endmodule

// ---- rtl/frp_apb_regs.sv ----
// APB slave decode and read mux of the protection block
module frp_apb_regs
  import frp_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] level_word,
  input wire logic [31:0] wpa0_word,
  input wire logic [31:0] wpa1_word,
  input wire logic [31:0] acc_word,
  input wire logic [31:0] verdict_word,
  input wire logic [31:0] otp_word,
  output logic wr_stb,
  output logic rd_stb,
  output logic hit,
  output logic [31:0] rdata
);
  always_comb begin
    wr_stb = psel && penable && pwrite;
    rd_stb = psel && penable && !pwrite;
    hit = 1'b1;
    case (paddr)
      FRP_OFS_LEVEL: rdata = level_word;
      FRP_OFS_WPA0: rdata = wpa0_word;
      FRP_OFS_WPA1: rdata = wpa1_word;
      FRP_OFS_KEY: rdata = FRP_RST_ZERO; // Key never reads back
      FRP_OFS_REQ: rdata = FRP_RST_ZERO;
      FRP_OFS_STAT: rdata = stat_word;
      FRP_OFS_ACC: rdata = acc_word;
      FRP_OFS_VERDCT: rdata = verdict_word;
      FRP_OFS_OTPST: rdata = otp_word;
      default: begin
        rdata = FRP_RST_ZERO;
        hit = 1'b0;
      end
    endcase
  end
endmodule

// ---- rtl/frp_pkg.sv ----
// Package: constants and types of the flash readout protection block
package frp_pkg;
  // Register byte offsets
  localparam logic [11:0] FRP_OFS_LEVEL  = 12'h000;
  localparam logic [11:0] FRP_OFS_WPA0   = 12'h004;
  localparam logic [11:0] FRP_OFS_WPA1   = 12'h008;
  localparam logic [11:0] FRP_OFS_KEY    = 12'h00c;
  localparam logic [11:0] FRP_OFS_REQ    = 12'h010;
  localparam logic [11:0] FRP_OFS_STAT   = 12'h014;
  localparam logic [11:0] FRP_OFS_ACC    = 12'h018;
  localparam logic [11:0] FRP_OFS_VERDCT = 12'h01c;
  localparam logic [11:0] FRP_OFS_OTPST  = 12'h020;

  // Level encodings as held in option bytes
  localparam logic [1:0] FRP_LVL_0   = 2'h0;
  localparam logic [1:0] FRP_LVL_0P5 = 2'h1;
  localparam logic [1:0] FRP_LVL_1   = 2'h2;
  localparam logic [1:0] FRP_LVL_2   = 2'h3;

  // Flash geometry
  localparam int FRP_PAGES = 128;
  localparam int FRP_PAGE_W = 7;
  localparam int FRP_OTP_ROWS = 32;
  localparam int FRP_OTP_W = 5;

  // Field positions
  localparam int FRP_F_WPA_START = 0;
  localparam int FRP_F_WPA_END = 8;
  localparam int FRP_F_WPA_EN = 16;

  // Reset values
  localparam logic [31:0] FRP_RST_ZERO = 32'h0000_0000;

  // Wipe walks through this many units, one per cycle
  localparam int FRP_WIPE_CYCLES = 128;

  typedef enum logic [1:0] {
    FRP_AREA_MAIN   = 2'h0,
    FRP_AREA_SYSMEM = 2'h1,
    FRP_AREA_OTP    = 2'h2,
    FRP_AREA_BKP    = 2'h3
  } frp_area_e;

  typedef enum logic [1:0] {
    FRP_OP_READ  = 2'h0,
    FRP_OP_WRITE = 2'h1,
    FRP_OP_ERASE = 2'h2
  } frp_op_e;

  // Access presented for checking
  typedef struct packed {
    logic valid;
    frp_area_e area;
    frp_op_e op;
    logic debug;
    logic ram_boot;
    logic secure;
    logic sram2;
    logic [FRP_PAGE_W-1:0] page;
    logic [FRP_OTP_W-1:0] otp_row;
  } frp_acc_s;

  // Write protect area: start and end page
  typedef struct packed {
    logic en;
    logic [FRP_PAGE_W-1:0] start;
    logic [FRP_PAGE_W-1:0] last;
  } frp_wpa_s;

  typedef enum logic [1:0] {
    FRP_ST_IDLE = 2'b00,
    FRP_ST_WIPE = 2'b01,
    FRP_ST_DONE = 2'b11
  } frp_state_e;
endpackage

// ---- rtl/frp_top.sv ----
// Top of the flash readout protection block with its APB register file
//
// Function
// RQ1 - Four protection levels: 0, 0.5, 1, 2
// RQ2 - Level 0.5 valid only with security extension
// RQ3 - Level 0.5 allows non-secure access except protected writes
// RQ4 - Level 0.5 blocks debug to secure region
// RQ5 - Level 1 denies flash to debug, RAM boot
// RQ6 - Level 1 secure: non-secure debug, no SRAM boot
// RQ7 - Leaving level 1 may need matching password
// RQ8 - Level 2 disables debug, RAM boot, bootloader
// RQ9 - Level 2 permanent without configured key
// RQ10 - Level 2 to 1 with key and password
// RQ11 - Two write protect areas block program, erase
// RQ12 - Flash is 128 pages of 8 Kbytes
// RQ13 - 512-byte OTP readable at every level; the code refuses debug and RAM boot reads of it at level 2
// RQ14 - Level 1 without extension: system memory, options ok
// RQ15 - Level 1 to 0 erases flash main
// RQ16 - Level 1 to 0 clears backup registers
// RQ17 - Level 1 to 0 erases all SRAM
// RQ18 - Each OTP row programs only once
// RQ19 - Denied access flagged as bus error
// RQ20 - Level latched from option bytes at reset; the code resets to level 2 and loads it on each opt_load strobe
module frp_top
  import frp_pkg::*;
#(
  parameter int PAGES = FRP_PAGES,
  parameter int WIPE_CYCLES = FRP_WIPE_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opt_load,
  input wire logic [1:0] opt_level,
  input wire logic opt_sec_ext,
  input wire logic opt_key_set,
  input wire logic [31:0] opt_password,
  input wire frp_acc_s mem_acc,
  output logic mem_grant,
  output logic mem_error,
  output logic debug_enable,
  output logic ram_boot_enable,
  output logic flash_wipe,
  output logic backup_clear,
  output logic sram_wipe
);
  logic [1:0] level_q, level_d;
  logic sec_ext_q, sec_ext_d;
  logic key_set_q, key_set_d;
  logic [31:0] pw_q, pw_d;
  logic [31:0] key_q, key_d;
  frp_wpa_s wpa0_q, wpa0_d, wpa1_q, wpa1_d;
  logic [FRP_OTP_ROWS-1:0] otp_used_q, otp_used_d;
  logic pw_fail_q, pw_fail_d;
  frp_acc_s sw_acc_q, sw_acc_d;
  logic sw_deny_q, sw_deny_d;
  frp_state_e st_q, st_d;
  logic [7:0] wipe_cnt_q, wipe_cnt_d;
  logic grant_q, grant_d, err_q, err_d;
  logic dbg_q, dbg_d, rboot_q, rboot_d;
  logic fw_q, fw_d, bk_q, bk_d, sw_q, sw_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  logic hw_deny, sw_deny_now;
  logic wr_stb, hit;
  logic [31:0] rd_word;
  logic opt_load_s1_q, opt_load_s2_q, opt_load_s3_q;

  frp_access_check u_chk_hw (
    .level(level_q),
    .sec_ext(sec_ext_q),
    .wpa0(wpa0_q),
    .wpa1(wpa1_q),
    .acc(mem_acc),
    .otp_used(otp_used_q[mem_acc.otp_row]),
    .deny(hw_deny)
  );

  frp_access_check u_chk_sw (
    .level(level_q),
    .sec_ext(sec_ext_q),
    .wpa0(wpa0_q),
    .wpa1(wpa1_q),
    .acc(sw_acc_q),
    .otp_used(otp_used_q[sw_acc_q.otp_row]),
    .deny(sw_deny_now)
  );

  frp_apb_regs u_regs (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .stat_word({20'h0, pw_fail_q, key_set_q, st_q, wipe_cnt_q}),
    .level_word({29'h0, sec_ext_q, level_q}),
    .wpa0_word({15'h0, wpa0_q.en, 1'b0, wpa0_q.last, 1'b0, wpa0_q.start}),
    .wpa1_word({15'h0, wpa1_q.en, 1'b0, wpa1_q.last, 1'b0, wpa1_q.start}),
    .acc_word({11'h0, sw_acc_q}),
    .verdict_word({31'h0, sw_deny_q}),
    .otp_word(otp_used_q),
    .wr_stb(wr_stb),
    .rd_stb(),
    .hit(hit),
    .rdata(rd_word)
  );

  function automatic frp_wpa_s wpa_from(input logic [31:0] w);
    wpa_from.en = w[FRP_F_WPA_EN];
    wpa_from.start = w[FRP_F_WPA_START +: FRP_PAGE_W];
    wpa_from.last = w[FRP_F_WPA_END +: FRP_PAGE_W];
  endfunction

  // Sanitise an option level: 0.5 needs the extension
  function automatic logic [1:0] legal_lvl(input logic [1:0] l,
                                          input logic se);
    legal_lvl = (l == FRP_LVL_0P5 && !se) ? FRP_LVL_1 : l; // see RQ1 see RQ2
  endfunction

  // Load strobe comes from the option loader, outside this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_load_s1_q <= 1'b0;
      opt_load_s2_q <= 1'b0;
      opt_load_s3_q <= 1'b0;
    end else begin
      opt_load_s1_q <= opt_load;
      opt_load_s2_q <= opt_load_s1_q;
      opt_load_s3_q <= opt_load_s2_q;
    end
  end

  logic req_wr, lvl_wr, load_evt, pw_ok, pw_ok_any;
  logic [1:0] want;
  always_comb begin
    level_d = level_q;
    sec_ext_d = sec_ext_q;
    key_set_d = key_set_q;
    pw_d = pw_q;
    key_d = key_q;
    wpa0_d = wpa0_q;
    wpa1_d = wpa1_q;
    otp_used_d = otp_used_q;
    pw_fail_d = pw_fail_q;
    sw_acc_d = sw_acc_q;
    st_d = st_q;
    wipe_cnt_d = wipe_cnt_q;
    fw_d = 1'b0;
    bk_d = 1'b0;
    sw_d = 1'b0;
    load_evt = opt_load_s2_q && !opt_load_s3_q;
    req_wr = wr_stb && paddr == FRP_OFS_REQ;
    lvl_wr = req_wr && pstrb[0];
    want = legal_lvl(pwdata[1:0], sec_ext_q);
    pw_ok = (key_q == pw_q);
    pw_ok_any = pw_ok || !key_set_q;
    // Level taken from option bytes only on a load
    if (load_evt) begin
      level_d = legal_lvl(opt_level, opt_sec_ext); // see RQ20
      sec_ext_d = opt_sec_ext;
      key_set_d = opt_key_set;
      pw_d = opt_password;
    end
    if (wr_stb && st_q != FRP_ST_WIPE) begin
      if (paddr == FRP_OFS_WPA0 && pstrb[0])
        wpa0_d = wpa_from(pwdata);
      if (paddr == FRP_OFS_WPA1 && pstrb[0])
        wpa1_d = wpa_from(pwdata);
      if (paddr == FRP_OFS_KEY)
        key_d = pwdata;
      if (paddr == FRP_OFS_ACC)
        sw_acc_d = frp_acc_s'(pwdata[20:0]);
    end
    if (lvl_wr && st_q != FRP_ST_WIPE && !load_evt) begin
      pw_fail_d = 1'b0;
      if (want > level_q) begin
        level_d = want;
      end else if (want < level_q) begin
        case (level_q)
          FRP_LVL_2: begin
            // Only to level 1, only with key and password
            if (want == FRP_LVL_1 && key_set_q && pw_ok)
              level_d = FRP_LVL_1; // see RQ9 see RQ10
            else
              pw_fail_d = 1'b1;
          end
          FRP_LVL_1: begin
            if (pw_ok_any) begin // see RQ7
              level_d = want;
              st_d = FRP_ST_WIPE;
              wipe_cnt_d = 8'h00;
            end else begin
              pw_fail_d = 1'b1;
            end
          end
          default: level_d = want;
        endcase
      end
    end
    // Wipe walks WIPE_CYCLES units, one per cycle, with erase strobes held
    case (st_q)
      FRP_ST_IDLE: st_d = st_d;
      FRP_ST_WIPE: begin
        wipe_cnt_d = wipe_cnt_q + 8'h01;
        if (wipe_cnt_q == 8'(WIPE_CYCLES - 1)) begin
          st_d = FRP_ST_DONE;
          otp_used_d = otp_used_q; // OTP survives the wipe
        end
      end
      // A request taken in this cycle may already start a new wipe
      FRP_ST_DONE: st_d = (st_d == FRP_ST_WIPE) ? st_d : FRP_ST_IDLE;
      default: st_d = FRP_ST_IDLE;
    endcase
    // Strobes follow the next state so they cover the refusal window
    if (st_d == FRP_ST_WIPE) begin
      fw_d = (level_d == FRP_LVL_0); // see RQ15
      bk_d = 1'b1; // see RQ16
      sw_d = 1'b1; // see RQ17
    end
    // Rows burn once; an OTP program not refused by hw_deny marks its row, even during a wipe
    if (mem_acc.valid && !hw_deny && mem_acc.area == FRP_AREA_OTP &&
        mem_acc.op == FRP_OP_WRITE)
      otp_used_d[mem_acc.otp_row] = 1'b1; // see RQ18
  end

  always_comb begin
    sw_deny_d = sw_deny_now;
    // Denied accesses turn into errors, nothing passes on
    grant_d = mem_acc.valid && !hw_deny && st_q != FRP_ST_WIPE; // see RQ19
    err_d = mem_acc.valid && !grant_d; // see RQ19
    dbg_d = level_q != FRP_LVL_2; // see RQ8 see RQ9
    rboot_d = !(level_q == FRP_LVL_2 ||
               (level_q == FRP_LVL_1 && sec_ext_q)); // see RQ6 see RQ8
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !hit;
    prdata_d = (psel && !penable && !pwrite) ? rd_word : prdata_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= FRP_LVL_2;
      sec_ext_q <= 1'b0;
      key_set_q <= 1'b0;
      pw_q <= FRP_RST_ZERO;
      key_q <= FRP_RST_ZERO;
      wpa0_q <= '0;
      wpa1_q <= '0;
      otp_used_q <= '0;
      pw_fail_q <= 1'b0;
      sw_acc_q <= '0;
      sw_deny_q <= 1'b0;
      st_q <= FRP_ST_IDLE;
      wipe_cnt_q <= 8'h00;
      grant_q <= 1'b0;
      err_q <= 1'b0;
      dbg_q <= 1'b0;
      rboot_q <= 1'b0;
      fw_q <= 1'b0;
      bk_q <= 1'b0;
      sw_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= FRP_RST_ZERO;
    end else begin
      level_q <= level_d;
      sec_ext_q <= sec_ext_d;
      key_set_q <= key_set_d;
      pw_q <= pw_d;
      key_q <= key_d;
      wpa0_q <= wpa0_d;
      wpa1_q <= wpa1_d;
      otp_used_q <= otp_used_d;
      pw_fail_q <= pw_fail_d;
      sw_acc_q <= sw_acc_d;
      sw_deny_q <= sw_deny_d;
      st_q <= st_d;
      wipe_cnt_q <= wipe_cnt_d;
      grant_q <= grant_d;
      err_q <= err_d;
      dbg_q <= dbg_d;
      rboot_q <= rboot_d;
      fw_q <= fw_d;
      bk_q <= bk_d;
      sw_q <= sw_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_grant = grant_q;
  assign mem_error = err_q;
  assign debug_enable = dbg_q;
  assign ram_boot_enable = rboot_q;
  assign flash_wipe = fw_q;
  assign backup_clear = bk_q;
  assign sram_wipe = sw_q;
endmodule
